// ===== verilog/atrig_pkg.sv
package atrig_pkg;

   // =====================================================================
   // trigger modes and sources
   typedef enum logic [2:0] {
      mode_below_low,
      mode_above_high,
      mode_inside_region,
      mode_high_hysteresis,
      mode_low_hysteresis
   } trig_mode_type;

   typedef enum logic {
      src_direct_pin,
      src_post_gain
   } trig_source_type;

   // =====================================================================
   // level widths: 256 steps (low res) or 4,096 steps (high res)
   localparam int LOW_RES_BITS  = 8;
   localparam int HIGH_RES_BITS = 12;
   localparam int LEVEL_BITS    = HIGH_RES_BITS;

   typedef struct packed {
      trig_source_type          source;
      trig_mode_type            mode;
      logic [LEVEL_BITS-1:0]    lower_threshold;
      logic [LEVEL_BITS-1:0]    upper_threshold;
   } trig_config_type;

   localparam logic [LEVEL_BITS-1:0] LEVEL_RESET = 12'h000;

endpackage

// ===== verilog/analog_trigger_level_compare.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - analog trigger offered beside software and external digital starts
// - source select: direct trigger pin sample or amplifier output sample
// - direct source levels span plus/minus 10 V at variant resolution
// - post-gain levels span channel full scale, 256 or 4096 steps
// - five modes, lower and upper thresholds written independently
// - below-low: trigger while signal under lower threshold
// - above-high: trigger while signal over upper threshold
// - inside-region: trigger while signal between the two thresholds
// - high-hysteresis: trigger when signal exceeds upper threshold
// - low-hysteresis: trigger when signal falls below lower threshold
// - comparison becomes one internal digital trigger for timing sections
module analog_trigger_level_compare
   import atrig_pkg::*;
#(
   parameter int LEVEL_WIDTH     = LEVEL_BITS,
   parameter int RESOLUTION_BITS = HIGH_RES_BITS
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // digitised samples, same clock domain (offset binary)
   input  wire logic [LEVEL_WIDTH-1:0] direct_trigger_input_pin,
   input  wire logic [LEVEL_WIDTH-1:0] programmable_gain_amplifier,
   // software configuration
   input  wire trig_config_type        trig_config,
   // to the acquisition timing controller
   output logic                        analog_trigger,
   output logic                        trigger_crossing
);

   // =====================================================================
   // level resolution
   // the coarse variant keeps only the top RESOLUTION_BITS of each
   // level; samples keep full width, so the step follows the level grid
   localparam int IGNORED_BITS = LEVEL_WIDTH - RESOLUTION_BITS;

   logic [LEVEL_WIDTH-1:0] lower_level;
   logic [LEVEL_WIDTH-1:0] upper_level;

   for (genvar b = 0; b < LEVEL_WIDTH; b++) begin : g_level_bit
      if (b < IGNORED_BITS) begin : g_dropped
         assign lower_level[b] = 1'b0;
         assign upper_level[b] = 1'b0;
      end else begin : g_kept
         assign lower_level[b] = trig_config.lower_threshold[b];
         assign upper_level[b] = trig_config.upper_threshold[b];
      end
   end

   // =====================================================================
   // selected sample, same clock as this block
   logic [LEVEL_WIDTH-1:0] sample;
   logic                   below_low;
   logic                   above_high;

   always_comb begin
      sample = (trig_config.source == src_post_gain) ?
               programmable_gain_amplifier :
               direct_trigger_input_pin;
   end

   // offset binary keeps the unsigned order across zero volts
   assign below_low  = sample < lower_level;
   assign above_high = sample > upper_level;

   // =====================================================================
   // mode decode
   logic                   armed;
   logic                   in_region;
   logic                   high_hyst_term;
   logic                   low_hyst_term;
   logic                   next_trigger;

   // inclusive at both levels; the single-level modes compare strictly
   assign in_region = !below_low && !above_high;

   // armed: wait for the near level; disarmed: hold until the far one
   assign high_hyst_term = armed ? above_high : !below_low;
   assign low_hyst_term  = armed ? below_low  : !above_high;

   always_comb begin
      next_trigger = 1'b0;
      unique case (trig_config.mode)
         mode_below_low: begin
            next_trigger = below_low;
         end
         mode_above_high: begin
            next_trigger = above_high;
         end
         mode_inside_region: begin
            next_trigger = in_region;
         end
         mode_high_hysteresis: begin
            next_trigger = high_hyst_term;
         end
         mode_low_hysteresis: begin
            next_trigger = low_hyst_term;
         end
         default: begin
            next_trigger = 1'b0;
         end
      endcase
   end

   // =====================================================================
   // hysteresis arming
   // disarmed exactly while a hysteresis trigger stands, so noise at
   // one level cannot fire again before the far level is passed;
   // a trigger left over from a level mode never counts as a hold
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armed <= 1'b1;
      end else if (trig_config.mode == mode_high_hysteresis ||
                   trig_config.mode == mode_low_hysteresis) begin
         armed <= !next_trigger;
      end else begin
         armed <= 1'b1;
      end
   end

   // =====================================================================
   // trigger output and crossing pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         analog_trigger <= 1'b0;
      end else begin
         analog_trigger <= next_trigger;
      end
   end

   // one-cycle pulse per rising trigger, for per-crossing consumers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trigger_crossing <= 1'b0;
      end else begin
         trigger_crossing <= next_trigger && !analog_trigger;
      end
   end

   // =====================================================================
   // checks: level modes
   default clocking check_clk @(posedge clk);
   endclocking
   default disable iff (rst);

   below_mode_a: assert property (
      trig_config.mode == mode_below_low
      |=>
      analog_trigger == $past(sample < lower_level)
   ) else $error("below-low trigger mismatch");

   below_edge_a: assert property (
      trig_config.mode == mode_below_low && sample == lower_level
      |=>
      !analog_trigger
   ) else $error("below-low fired at the level");

   above_mode_a: assert property (
      trig_config.mode == mode_above_high
      |=>
      analog_trigger == $past(sample > upper_level)
   ) else $error("above-high trigger mismatch");

   above_edge_a: assert property (
      trig_config.mode == mode_above_high && sample == upper_level
      |=>
      !analog_trigger
   ) else $error("above-high fired at the level");

   inside_mode_a: assert property (
      trig_config.mode == mode_inside_region
      |=>
      analog_trigger == $past(sample >= lower_level && sample <= upper_level)
   ) else $error("inside-region trigger mismatch");

   inside_low_a: assert property (
      trig_config.mode == mode_inside_region && sample == lower_level
      && lower_level <= upper_level
      |=>
      analog_trigger
   ) else $error("inside-region lower end not included");

   inside_high_a: assert property (
      trig_config.mode == mode_inside_region && sample == upper_level
      && lower_level <= upper_level
      |=>
      analog_trigger
   ) else $error("inside-region upper end not included");

   mode_idle_a: assert property (
      trig_config.mode > mode_low_hysteresis
      |=>
      !analog_trigger
   ) else $error("unused mode code fired");

   // =====================================================================
   // checks: hysteresis modes
   high_fire_a: assert property (
      trig_config.mode == mode_high_hysteresis && armed && above_high
      |=>
      analog_trigger
   ) else $error("high hysteresis did not fire");

   high_hold_a: assert property (
      trig_config.mode == mode_high_hysteresis && !armed && !below_low
      |=>
      analog_trigger
   ) else $error("high hysteresis dropped early");

   high_drop_a: assert property (
      trig_config.mode == mode_high_hysteresis && !armed && below_low
      |=>
      !analog_trigger
   ) else $error("high hysteresis held past lower level");

   high_rearm_a: assert property (
      trig_config.mode == mode_high_hysteresis && !analog_trigger
      && !above_high
      |=>
      !analog_trigger
   ) else $error("high hysteresis fired below upper level");

   low_fire_a: assert property (
      trig_config.mode == mode_low_hysteresis && armed && below_low
      |=>
      analog_trigger
   ) else $error("low hysteresis did not fire");

   low_hold_a: assert property (
      trig_config.mode == mode_low_hysteresis && !armed && !above_high
      |=>
      analog_trigger
   ) else $error("low hysteresis dropped early");

   low_drop_a: assert property (
      trig_config.mode == mode_low_hysteresis && !armed && above_high
      |=>
      !analog_trigger
   ) else $error("low hysteresis held past upper level");

   low_rearm_a: assert property (
      trig_config.mode == mode_low_hysteresis && !analog_trigger
      && !below_low
      |=>
      !analog_trigger
   ) else $error("low hysteresis fired above lower level");

   arm_idle_a: assert property (
      trig_config.mode != mode_high_hysteresis
      && trig_config.mode != mode_low_hysteresis
      |=>
      armed
   ) else $error("left disarmed outside hysteresis");

   // =====================================================================
   // checks: source select and crossing pulse
   source_post_a: assert property (
      trig_config.source == src_post_gain
      && trig_config.mode == mode_above_high
      && programmable_gain_amplifier > upper_level
      |=>
      analog_trigger
   ) else $error("post-gain source not used");

   source_direct_a: assert property (
      trig_config.source == src_direct_pin
      && trig_config.mode == mode_above_high
      && direct_trigger_input_pin > upper_level
      |=>
      analog_trigger
   ) else $error("direct pin source not used");

   crossing_pulse_a: assert property (
      trigger_crossing
      |->
      analog_trigger && !$past(analog_trigger)
   ) else $error("crossing pulse without rise");

   crossing_rise_a: assert property (
      analog_trigger && !$past(analog_trigger)
      |->
      trigger_crossing
   ) else $error("rise without crossing pulse");

   crossing_single_a: assert property (
      trigger_crossing
      |=>
      !trigger_crossing
   ) else $error("crossing pulse longer than one cycle");

   // =====================================================================
   // main scenarios
   below_c: cover property (
      trig_config.mode == mode_below_low && trigger_crossing);

   above_c: cover property (
      trig_config.mode == mode_above_high && trigger_crossing);

   inside_c: cover property (
      trig_config.mode == mode_inside_region && trigger_crossing);

   high_hyst_c: cover property (
      trig_config.mode == mode_high_hysteresis && trigger_crossing);

   low_hyst_c: cover property (
      trig_config.mode == mode_low_hysteresis && trigger_crossing);

endmodule

`default_nettype wire

// ===== sim/scan_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// timing section: one start per crossing
module scan_counter (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // from the trigger block
   input  wire logic        trigger_crossing,
   output logic [15:0]      crossings
);
   // level ignored, only crossings start scans
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         crossings <= 16'h0000;
      else if (trigger_crossing)
         crossings <= crossings + 16'h0001;
   end
endmodule
`default_nettype wire

// ===== sim/analog_trigger_level_compare_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// random levels and samples, model in step
module analog_trigger_level_compare_tb;
   import atrig_pkg::*;
   logic            clk = 0;
   logic            rst = 1;
   logic            trg;
   logic            crs;
   logic [11:0]     pin = 12'h000;
   logic [11:0]     amp = 12'h000;
   trig_config_type cfg = '0;
   logic [15:0]     crossings;
   logic            e_trg = 0;
   logic            e_crs = 0;
   logic            e_arm = 1;
   logic [15:0]     e_cnt = 16'h0000;
   logic [31:0]     seed = 32'h0000005b;
   int              n_fail = 0;
   int              check_count = 0;
   always #2.5 clk = ~clk;
   analog_trigger_level_compare u_analog_trigger_level_compare (
      .clk(clk), .rst(rst), .direct_trigger_input_pin(pin),
      .programmable_gain_amplifier(amp), .trig_config(cfg),
      .analog_trigger(trg), .trigger_crossing(crs));
   scan_counter u_scan_counter (.clk(clk), .rst(rst),
      .trigger_crossing(crs), .crossings(crossings));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step();
      logic [11:0] s;
      logic [11:0] lo;
      logic [11:0] up;
      logic        t;
      s = (cfg.source == src_post_gain) ? amp : pin;
      lo = cfg.lower_threshold;
      up = cfg.upper_threshold;
      case (cfg.mode)
         mode_below_low:       t = s < lo;
         mode_above_high:      t = s > up;
         mode_inside_region:   t = (s >= lo) && (s <= up);
         mode_high_hysteresis: t = e_arm ? (s > up) : (s >= lo);
         mode_low_hysteresis:  t = e_arm ? (s < lo) : (s <= up);
         default:              t = 1'b0;
      endcase
      // hysteresis: disarmed exactly while the trigger stands
      e_arm = (cfg.mode == mode_high_hysteresis ||
               cfg.mode == mode_low_hysteresis) ? !t : 1'b1;
      // the partner's count lags the crossing pulse by one edge
      e_cnt = e_cnt + {15'h0000, e_crs};
      e_crs = t && !e_trg;
      e_trg = t;
   endtask
   task automatic results();
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // outputs judged at negedge, after the sampling posedge
   always @(negedge clk) begin
      if (rst) begin
         e_trg = 0;
         e_crs = 0;
         e_arm = 1;
         e_cnt = 16'h0000;
      end else
         step();
      check({15'h0000, trg}, {15'h0000, e_trg});
      check({15'h0000, crs}, {15'h0000, e_crs});
      check(crossings, e_cnt);
   end
   initial begin
      #30000;
      n_fail++;
      results();
   end
   initial begin
      repeat (10) @(negedge clk);
      rst <= 0;
      for (int i = 0; i < 3000; i++) begin
         @(negedge clk);
         seed = xs(seed);
         // a below-low cycle rearms before any mode change
         if (i % 40 == 39)
            cfg.mode <= mode_below_low;
         if (i % 40 == 0) begin
            cfg.mode <= trig_mode_type'(seed[2:0]);
            cfg.source <= trig_source_type'(seed[3]);
            cfg.lower_threshold <= seed[15:4];
            cfg.upper_threshold <= seed[15:4] + {4'h0, seed[23:16]};
         end
         // direct pin samples land on the thresholds half the time
         case (seed[25:24])
            2'h0:    pin <= cfg.lower_threshold;
            2'h1:    pin <= cfg.upper_threshold;
            default: pin <= seed[31:20];
         endcase
         amp <= seed[26] ? pin : seed[11:0];
         if (i == 1500 || i == 1502)
            rst <= (i == 1500);
      end
      results();
   end
endmodule
`default_nettype wire
